//--- pkg/adsrc_defs.svh
// Constants for the converter serial, ready and rate control block.
// Assumes inclusion by bare name from any file of the block.
`ifndef ADSRC_DEFS_SVH
`define ADSRC_DEFS_SVH

// ----------------------------------------------------------------------
// Widths and limits
// ----------------------------------------------------------------------
`define ADSRC_WORD_W      24
`define ADSRC_DEC_W       11
`define ADSRC_DEC_MIN     11'd20
`define ADSRC_DEC_MAX     11'd2047
`define ADSRC_DIV_W       8

// ----------------------------------------------------------------------
// Modulator division factors, last count of each divider
// ----------------------------------------------------------------------
`define ADSRC_MF128_LAST  8'h7f
`define ADSRC_MF256_LAST  8'hff

// ----------------------------------------------------------------------
// Gain codes (gain = 2**code) that change the sampling multiplier
// ----------------------------------------------------------------------
`define ADSRC_GAIN16      3'h4
`define ADSRC_GAIN32      3'h5

// ----------------------------------------------------------------------
// Serial command bytes and frame lengths
// ----------------------------------------------------------------------
`define ADSRC_CMD_RDATA   8'h01
`define ADSRC_CMD_RMODE   8'h10
`define ADSRC_CMD_LAST    5'd7
`define ADSRC_DATA_LAST   5'd23
`define ADSRC_MODE_LAST   5'd7
`define ADSRC_RDY_BIT     7

`endif

//--- pkg/adsrc_pkg.sv
// Types shared by the converter control block.
// Assumes the constants header sits beside it.
package adsrc_pkg;
    // Digital filter choice, also the auto sequencing stages.
    typedef enum logic [1:0] {
        ADSRC_FILT_FAST,
        ADSRC_FILT_SINC2,
        ADSRC_FILT_SINC3,
        ADSRC_FILT_AUTO
    } adsrc_filt_e;
    // Signed conversion word.
    typedef logic signed [23:0] adsrc_word_t;
endpackage

//--- pkg/adsrc_tim_if.sv
// Interface between the serial control top and the timing module.
// Assumes both ends run on the same reference clock.
`timescale 1ns/1ps
`default_nettype none
interface adsrc_tim_if;
    import adsrc_pkg::*;
    logic        speed;        // Divider select, 1 means 256.
    logic [2:0]  gain;         // Gain code, gain is 2**code.
    logic [10:0] dec_ratio;    // Requested decimation ratio.
    adsrc_filt_e filt_mode;    // Requested filter mode.
    logic [2:0]  chan;         // Selected input channel.
    logic        mod_tick;     // Modulator clock pulse.
    logic        samp_tick;    // Input sampling pulse.
    logic        pre_update;   // Result about to be loaded.
    logic        load;         // Result loaded this cycle.
    adsrc_filt_e stage;        // Filter in use now.
    logic        settled;      // Current filter has settled.
    modport timing (input speed, gain, dec_ratio, filt_mode, chan,
                     output mod_tick, samp_tick, pre_update, load, stage, settled);
    modport ctrl   (output speed, gain, dec_ratio, filt_mode, chan,
                     input mod_tick, samp_tick, pre_update, load, stage, settled);
endinterface
`default_nettype wire

//--- hdl/adsrc_timing.sv
// Conversion timing: modulator divider, decimation, sampling and filter settling.
// Assumes configuration arrives from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "adsrc_defs.svh"
module adsrc_timing (
    input  wire logic ref_clk_i,  // Oscillator clock.
    input  wire logic rst_n_i,    // Asynchronous reset, active low.
    adsrc_tim_if.timing tif       // Configuration in, timing out.
);
    import adsrc_pkg::*;

    // ------------------------------------------------------------------
    // Modulator divider
    // ------------------------------------------------------------------
    logic [7:0]  div_q;      // Oscillator cycles within one modulator period.
    logic [7:0]  div_last;   // Last count for the chosen factor.
    logic [7:0]  samp_mask;  // Low bits that must be all ones for a sample.
    logic        div_end;    // Modulator period ends.
    assign div_last = tif.speed ? `ADSRC_MF256_LAST : `ADSRC_MF128_LAST;
    assign div_end  = (div_q == div_last);
    assign samp_mask = (tif.gain < `ADSRC_GAIN16) ? div_last :
                       (tif.gain == `ADSRC_GAIN16) ? (div_last >> 1) :
                       (tif.gain == `ADSRC_GAIN32) ? (div_last >> 2) : (div_last >> 3);

    // Divider counter and tick pulses.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q         <= 8'h00;
            tif.mod_tick  <= 1'b0;
            tif.samp_tick <= 1'b0;
        end else begin
            div_q         <= div_end ? 8'h00 : div_q + 8'h01;
            tif.mod_tick  <= div_end;
            tif.samp_tick <= ((div_q & samp_mask) == samp_mask);
        end
    end

    // ------------------------------------------------------------------
    // Decimation
    // ------------------------------------------------------------------
    logic [10:0] dec_q;    // Modulator periods within one output word.
    logic [10:0] ratio;    // Ratio held inside the legal range.
    logic        dec_end;  // Last modulator period of the word.
    // Ratio limited to its legal range.
    assign ratio   = (tif.dec_ratio < `ADSRC_DEC_MIN) ? `ADSRC_DEC_MIN : tif.dec_ratio;
    assign dec_end = tif.mod_tick && (dec_q >= ratio - 11'd1);

    // Word counter; warns one cycle before the load.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dec_q          <= 11'h000;
            tif.pre_update <= 1'b0;
            tif.load       <= 1'b0;
        end else begin
            if (tif.mod_tick) begin
                dec_q <= dec_end ? 11'h000 : dec_q + 11'h001;
            end
            tif.pre_update <= dec_end;
            tif.load       <= tif.pre_update;
        end
    end

    // ------------------------------------------------------------------
    // Filter selection and settling
    // ------------------------------------------------------------------
    logic [2:0]  chan_q;     // Channel seen last cycle.
    adsrc_filt_e mode_q;     // Mode seen last cycle.
    logic [1:0]  periods_q;  // Words since channel or mode change, saturating.
    logic        restart;    // Channel or mode changed.
    logic [1:0]  need;       // Words the current filter needs to settle.
    assign restart = (tif.chan != chan_q) || (tif.filt_mode != mode_q);
    assign need = (tif.stage == ADSRC_FILT_FAST)  ? 2'd1 :
                  (tif.stage == ADSRC_FILT_SINC2) ? 2'd2 : 2'd3;

    // Stage register, auto sequence and settled flag.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chan_q      <= 3'h0;
            mode_q      <= ADSRC_FILT_FAST;
            periods_q   <= 2'd0;
            tif.stage   <= ADSRC_FILT_FAST;
            tif.settled <= 1'b0;
        end else begin
            chan_q      <= tif.chan;
            mode_q      <= tif.filt_mode;
            tif.settled <= (periods_q >= need);
            if (restart) begin
                periods_q <= 2'd0;
                tif.stage <= (tif.filt_mode == ADSRC_FILT_AUTO) ? ADSRC_FILT_FAST : tif.filt_mode;
            end else if (tif.load) begin
                periods_q <= (periods_q == 2'd3) ? periods_q : periods_q + 2'd1;
                if (tif.filt_mode == ADSRC_FILT_AUTO && tif.stage != ADSRC_FILT_SINC3) begin
                    tif.stage <= (tif.stage == ADSRC_FILT_FAST) ? ADSRC_FILT_SINC2 : ADSRC_FILT_SINC3;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- hdl/adsrc_top.sv
// Serial interface, result ready handshake and rate control of the converter.
// Assumes sclk, cs_n and din are asynchronous pins; the rest is on ref_clk_i.
//
// What this block does
// - Ready goes low when word loaded.
// - Ready returns high after result read.
// - Ready rises just before each load.
// - Serial shifting is timed by sclk.
// - Transfers happen only while selected.
// - Chip select tied low gives three-wire.
// - Ready mirrored in mode register bit 7.
// - Filters settle in 1, 2, 3 periods.
// - Auto mode: fast, then sinc2, sinc3.
// - Modulator divides oscillator by 128 or 256.
// - Decimation 20 to 2047 sets rate.
// - Sampling multiplier grows with high gain.
// - Output codes are signed two's complement.
// - Back-to-back bursts without pauses are allowed.
`timescale 1ns/1ps
`default_nettype none
`include "adsrc_defs.svh"
module adsrc_top (
    input  wire logic                 ref_clk_i,         // Oscillator clock, 10 MHz.
    input  wire logic                 rst_n_i,           // Asynchronous reset, active low.
    input  wire logic                 sclk_i,            // Serial clock pin.
    input  wire logic                 cs_n_i,            // Chip select pin, active low.
    input  wire logic                 din_i,             // Serial data in pin.
    input  wire logic                 speed_i,           // Modulator divider select.
    input  wire logic [2:0]           gain_i,            // Gain code.
    input  wire logic [10:0]          dec_ratio_i,       // Decimation ratio.
    input  wire adsrc_pkg::adsrc_filt_e filt_mode_i,     // Filter mode.
    input  wire logic [2:0]           chan_i,            // Selected channel.
    input  wire adsrc_pkg::adsrc_word_t conv_word_i,     // Finished conversion word.
    output logic                      dout_o,            // Serial data out.
    output logic                      dout_oe_o,         // Data out driven.
    output logic                      result_ready_n_o,  // Result ready, active low.
    output adsrc_pkg::adsrc_word_t    output_result_o,   // Output result register.
    output logic                      mod_tick_o,        // Modulator clock pulse.
    output logic                      samp_tick_o,       // Input sampling pulse.
    output adsrc_pkg::adsrc_filt_e    filt_stage_o,      // Filter in use.
    output logic                      settled_o          // Current filter settled.
);
    import adsrc_pkg::*;

    // ------------------------------------------------------------------
    // Timing module
    // ------------------------------------------------------------------
    adsrc_tim_if tif ();
    assign tif.speed     = speed_i;
    assign tif.gain      = gain_i;
    assign tif.dec_ratio = (dec_ratio_i > `ADSRC_DEC_MAX) ? `ADSRC_DEC_MAX : dec_ratio_i;
    assign tif.filt_mode = filt_mode_i;
    assign tif.chan      = chan_i;

    adsrc_timing u_timing (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .tif       (tif)
    );

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] sclk_q;  // Two sync stages plus one edge history stage.
    logic [1:0] cs_q;    // Chip select sync stages.
    logic [1:0] din_q;   // Data in sync stages.
    logic       sclk_rise;  // Host samples rise.
    logic       sclk_fall;  // Device shifts on fall.
    logic       selected;   // Chip select low after sync.
    assign sclk_rise = sclk_q[1] && !sclk_q[2];
    assign sclk_fall = !sclk_q[1] && sclk_q[2];
    assign selected  = !cs_q[1];

    // Pins pass two flops before use.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_q <= 3'h0;
            cs_q   <= 2'h3;
            din_q  <= 2'h0;
        end else begin
            sclk_q <= {sclk_q[1:0], sclk_i};
            cs_q   <= {cs_q[0], cs_n_i};
            din_q  <= {din_q[0], din_i};
        end
    end

    // ------------------------------------------------------------------
    // Serial frame engine
    // ------------------------------------------------------------------
    typedef enum logic {ADSRC_SER_CMD, ADSRC_SER_DATA} adsrc_ser_e;
    adsrc_ser_e  ser_q;      // Command or data phase.
    logic [4:0]  bit_q;      // Bit within the phase.
    logic [4:0]  last_q;     // Last bit of the data phase.
    logic [7:0]  cmd_q;      // Command bits collected so far.
    logic        rd_data_q;  // Data phase reads the result.
    logic [23:0] out_q;      // Outgoing bits, MSB first.
    logic [7:0]  cmd_next;   // Command byte including this bit.
    logic [7:0]  mode_reg;   // Mode register view: ready, speed, filter mode and gain.
    logic        read_done;  // Last result bit taken by the host.
    assign cmd_next = {cmd_q[6:0], din_q[1]};
    assign mode_reg = {result_ready_n_o, speed_i, filt_mode_i, 1'b0, gain_i};
    assign read_done = (ser_q == ADSRC_SER_DATA) && sclk_rise && rd_data_q && (bit_q == last_q);

    // Shift in commands on rise, shift out data on fall.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ser_q     <= ADSRC_SER_CMD;
            bit_q     <= 5'd0;
            last_q    <= 5'd0;
            cmd_q     <= 8'h00;
            rd_data_q <= 1'b0;
            out_q     <= 24'h000000;
            dout_o    <= 1'b0;
            dout_oe_o <= 1'b0;
        end else if (!selected) begin
            ser_q     <= ADSRC_SER_CMD;
            bit_q     <= 5'd0;
            dout_oe_o <= 1'b0;
        end else begin
            dout_oe_o <= 1'b1;
            if (ser_q == ADSRC_SER_CMD && sclk_rise) begin
                cmd_q <= cmd_next;
                bit_q <= bit_q + 5'd1;
                if (bit_q == `ADSRC_CMD_LAST) begin
                    bit_q <= 5'd0;
                    if (cmd_next == `ADSRC_CMD_RDATA) begin
                        ser_q     <= ADSRC_SER_DATA;
                        out_q     <= output_result_o;
                        last_q    <= `ADSRC_DATA_LAST;
                        rd_data_q <= 1'b1;
                    end else if (cmd_next == `ADSRC_CMD_RMODE) begin
                        ser_q     <= ADSRC_SER_DATA;
                        out_q     <= {mode_reg, 16'h0000};
                        last_q    <= `ADSRC_MODE_LAST;
                        rd_data_q <= 1'b0;
                    end
                end
            end else if (ser_q == ADSRC_SER_DATA) begin
                if (sclk_fall) begin
                    dout_o <= out_q[`ADSRC_WORD_W-1];
                    out_q  <= {out_q[22:0], 1'b0};
                end
                if (sclk_rise) begin
                    bit_q <= (bit_q == last_q) ? 5'd0 : bit_q + 5'd1;
                    ser_q <= (bit_q == last_q) ? ADSRC_SER_CMD : ADSRC_SER_DATA;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Result register and ready handshake
    // ------------------------------------------------------------------
    // Load wins over the warning and the read end in the same cycle.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            output_result_o  <= 24'sh000000;
            result_ready_n_o <= 1'b1;
        end else if (tif.load) begin
            output_result_o  <= conv_word_i;
            result_ready_n_o <= 1'b0;
        end else if (tif.pre_update) begin
            result_ready_n_o <= 1'b1;
        end else if (read_done) begin
            result_ready_n_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------------
    // Timing status registered again at the top boundary.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mod_tick_o   <= 1'b0;
            samp_tick_o  <= 1'b0;
            filt_stage_o <= ADSRC_FILT_FAST;
            settled_o    <= 1'b0;
        end else begin
            mod_tick_o   <= tif.mod_tick;
            samp_tick_o  <= tif.samp_tick;
            filt_stage_o <= tif.stage;
            settled_o    <= tif.settled;
        end
    end
endmodule
`default_nettype wire

//--- tb/adsrc_checker.sv
// Port assertions for the converter serial, ready and rate control top.
// Assumes a bind onto adsrc_top and a single reference clock domain.
`timescale 1ns/1ps
`default_nettype none
module adsrc_checker (
    input wire logic                   ref_clk_i,
    input wire logic                   rst_n_i,
    input wire logic                   cs_n_i,
    input wire logic                   sclk_i,
    input wire logic                   speed_i,
    input wire logic [2:0]             chan_i,
    input wire adsrc_pkg::adsrc_filt_e filt_mode_i,
    input wire adsrc_pkg::adsrc_word_t conv_word_i,
    input wire logic                   dout_o,
    input wire logic                   dout_oe_o,
    input wire logic                   result_ready_n_o,
    input wire adsrc_pkg::adsrc_word_t output_result_o,
    input wire logic                   mod_tick_o,
    input wire adsrc_pkg::adsrc_filt_e filt_stage_o,
    input wire logic                   settled_o
);
    import adsrc_pkg::*;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [8:0] gap_q;  // Cycles since the last modulator pulse.
    logic       ok_q;   // Speed has held still since that pulse.
    logic [3:0] age_q;  // Cycles since ready last fell, saturating.
    // Helper counters, reset (age_q to its 4'hf ceiling) so no early interval is judged.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap_q <= 9'h000;
            ok_q  <= 1'b0;
            age_q <= 4'hf;
        end else begin
            gap_q <= mod_tick_o ? 9'h000 : gap_q + 9'h001;
            ok_q  <= $stable(speed_i) && (mod_tick_o || ok_q);
            age_q <= $fell(result_ready_n_o) ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
        end
    end
    chk_result_on_load: assert property (
        $changed(output_result_o) |-> $fell(result_ready_n_o)) else $error("result moved outside a load");
    chk_word_capture: assert property (
        $fell(result_ready_n_o) |-> output_result_o == $past(conv_word_i)) else $error("loaded word wrong");
    chk_mod_period: assert property (
        mod_tick_o && ok_q |-> gap_q == (speed_i ? 9'h0ff : 9'h07f)) else $error("modulator period wrong");
    chk_oe_select: assert property (
        $fell(cs_n_i) |-> ##[1:5] dout_oe_o) else $error("output not enabled on select");
    chk_oe_release: assert property (
        $rose(cs_n_i) |-> ##[1:5] !dout_oe_o) else $error("output still enabled after deselect");
    chk_dout_low_phase: assert property (
        $changed(dout_o) && $past(dout_oe_o) |-> !$past(sclk_i, 2)) else $error("dout moved in high phase");
    chk_settle_restart: assert property (
        $changed(chan_i) |-> ##[1:4] !settled_o) else $error("channel change kept settled");
    chk_settle_on_load: assert property (
        $rose(settled_o) |-> (age_q <= 4'h3) or ##[1:3] $fell(result_ready_n_o)) else $error("settled off a load");
    chk_auto_order: assert property (
        $changed(filt_stage_o) && filt_stage_o != ADSRC_FILT_FAST && filt_mode_i == ADSRC_FILT_AUTO
        && $past(filt_mode_i, 3) == ADSRC_FILT_AUTO && chan_i == $past(chan_i, 3)
        |-> filt_stage_o == adsrc_filt_e'($past(filt_stage_o) + 2'h1)) else $error("auto stage order wrong");
    cov_load: cover property ($fell(result_ready_n_o));
    cov_auto_done: cover property (filt_mode_i == ADSRC_FILT_AUTO && filt_stage_o == ADSRC_FILT_SINC3);
    cov_settled: cover property ($rose(settled_o));
endmodule
bind adsrc_top adsrc_checker adsrc_checker_i (.ref_clk_i, .rst_n_i, .cs_n_i, .sclk_i, .speed_i, .chan_i,
    .filt_mode_i, .conv_word_i, .dout_o, .dout_oe_o, .result_ready_n_o, .output_result_o, .mod_tick_o,
    .filt_stage_o, .settled_o);
`default_nettype wire

//--- tb/adsrc_host.sv
// Host serial master model driving the converter's serial pins.
// Assumes the reference clock paces it; sclk halves last five clocks.
`timescale 1ns/1ps
`default_nettype none
`include "adsrc_defs.svh"
module adsrc_host (
    input  wire logic ref_clk_i,         // Reference clock.
    input  wire logic dout_i,            // Serial data from the device.
    input  wire logic result_ready_n_i,  // Ready, active low.
    output logic      sclk_o,            // Serial clock, still between frames.
    output logic      cs_n_o,            // Chip select, active low.
    output logic      din_o              // Serial data to the device.
);
    logic three_wire = 1'b0;  // When set, select stays low between frames.
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        din_o  = 1'b0;
    end
    // one clocked bit: din set in the low half, dout taken at the rise.
    task automatic bit_x(input logic d, output logic q);
        @(posedge ref_clk_i);
        sclk_o <= 1'b0;
        din_o  <= d;
        repeat (5) @(posedge ref_clk_i);
        q = dout_i;
        sclk_o <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
    endtask
    // select held low over a gapless burst of command and data.
    task automatic frame(input logic [7:0] cmd, input int n, output logic [23:0] data);
        logic q;
        data = 24'h000000;
        @(posedge ref_clk_i);
        cs_n_o <= 1'b0;
        for (int i = 7; i >= 0; i--) bit_x(cmd[i], q);
        // A released data line toggles, so a stale level is never seen.
        for (int i = 0; i < n; i++) begin
            bit_x(~din_o, q);
            data = {data[22:0], q};
        end
        @(posedge ref_clk_i);
        cs_n_o <= three_wire ? 1'b0 : 1'b1;
        din_o  <= ~din_o;
    endtask
    // a result read waits for ready low, for at most 9000 cycles.
    task automatic read_result(output logic [23:0] data);
        int n;
        n = 0;
        while (result_ready_n_i !== 1'b0 && n < 9000) begin
            @(posedge ref_clk_i);
            n++;
        end
        frame(`ADSRC_CMD_RDATA, 24, data);
    endtask
endmodule
`default_nettype wire

//--- tb/adsrc_top_tb.sv
// Self-checking bench for the converter serial, ready and rate control.
// Assumes the host model on the serial pins and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "adsrc_defs.svh"
module adsrc_top_tb;
    import adsrc_pkg::*;
    logic        ref_clk_i   = 1'b0;
    logic        rst_n_i     = 1'b0;
    logic        speed_i     = 1'b0;
    logic [2:0]  gain_i      = 3'h0;
    logic [2:0]  chan_i      = 3'h0;
    logic [10:0] dec_ratio_i = 11'd20;
    adsrc_filt_e filt_mode_i = ADSRC_FILT_FAST;
    adsrc_word_t conv_word_i = 24'h800001;  // Negative full word first.
    wire logic   sclk_i, cs_n_i, din_i, dout_o, dout_oe_o, result_ready_n_o, mod_tick_o, samp_tick_o, settled_o;
    adsrc_word_t output_result_o;
    adsrc_filt_e filt_stage_o;
    int          miscompares = 0;
    int          compares    = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    adsrc_top adsrc_top_i (.ref_clk_i, .rst_n_i, .sclk_i, .cs_n_i, .din_i, .speed_i, .gain_i, .dec_ratio_i,
        .filt_mode_i, .chan_i, .conv_word_i, .dout_o, .dout_oe_o, .result_ready_n_o, .output_result_o,
        .mod_tick_o, .samp_tick_o, .filt_stage_o, .settled_o);
    adsrc_host adsrc_host_i (.ref_clk_i, .dout_i(dout_o), .result_ready_n_i(result_ready_n_o),
        .sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i));
    // Compares one value and reports a difference at once.
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] want);
        compares++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Waits for a ready fall; n is the cycle count, lows the low samples before it.
    task automatic wait_load(output int n, output int lows);
        logic p;
        p = result_ready_n_o;
        n = 0;
        lows = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
            if (p === 1'b0) lows++;
            if (p === 1'b1 && result_ready_n_o === 1'b0) break;
            p = result_ready_n_o;
        end while (n < 9000);
    endtask
    // Counts cycles between two sampling pulses.
    task automatic tick_gap(output int n);
        int w;
        w = 0;
        do begin @(posedge ref_clk_i); w++; end while (samp_tick_o !== 1'b1 && w < 600);
        n = 0;
        do begin @(posedge ref_clk_i); n++; end while (samp_tick_o !== 1'b1 && n < 600);
    endtask
    task automatic test_ready();
        logic [23:0] d;
        int n, l;
        wait_load(n, l);
        check("first result", output_result_o, 24'h800001);
        conv_word_i <= 24'h123456;
        adsrc_host_i.read_result(d);
        check("serial word", d, 24'h800001);
        repeat (4) @(posedge ref_clk_i);
        check("ready after read", result_ready_n_o, 1'b1);
        wait_load(n, l);
        check("low while idle", 24'(l), 24'h0);
        check("next result", output_result_o, 24'h123456);
        $display("done: handshake");
    endtask
    task automatic test_rates();
        logic        spd [3]  = '{1'b1, 1'b0, 1'b0};
        logic [10:0] dec [3]  = '{11'd20, 11'd19, 11'd33};
        int          want [3] = '{5120, 2560, 4224};
        int n, l;
        for (int i = 0; i < 3; i++) begin
            speed_i <= spd[i];
            dec_ratio_i <= dec[i];
            wait_load(n, l);
            wait_load(n, l);
            check("word period", 24'(n), 24'(want[i]));
        end
        speed_i <= 1'b0;
        dec_ratio_i <= 11'd20;
        $display("done: rates");
    endtask
    task automatic test_sampling();
        logic [2:0] code [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
        int         want [5] = '{128, 64, 32, 16, 16};
        int n;
        for (int i = 0; i < 5; i++) begin
            gain_i <= code[i];
            tick_gap(n);
            tick_gap(n);
            check("sampling gap", 24'(n), 24'(want[i]));
        end
        $display("done: sampling");
    endtask
    task automatic test_three_wire();
        logic [23:0] d;
        int n, l;
        adsrc_host_i.three_wire = 1'b1;
        wait_load(n, l);
        adsrc_host_i.frame(`ADSRC_CMD_RMODE, 8, d);
        check("mode ready low", d, {16'h0, 1'b0, speed_i, filt_mode_i, 1'b0, gain_i});
        adsrc_host_i.read_result(d);
        check("three-wire word", d, 24'h123456);
        adsrc_host_i.frame(`ADSRC_CMD_RMODE, 8, d);
        check("mode ready high", d[7], 1'b1);
        check("select held", dout_oe_o, 1'b1);
        @(posedge ref_clk_i);
        adsrc_host_i.cs_n_o <= 1'b1;
        adsrc_host_i.three_wire = 1'b0;
        repeat (6) @(posedge ref_clk_i);
        check("deselected", dout_oe_o, 1'b0);
        $display("done: three-wire");
    endtask
    task automatic test_filters();
        int n, l;
        for (int m = 0; m < 4; m++) begin
            filt_mode_i <= adsrc_filt_e'(m);
            wait_load(n, l);
            chan_i <= chan_i + 3'h1;
            for (int k = 1; k <= 3; k++) begin
                wait_load(n, l);
                repeat (3) @(posedge ref_clk_i);
                if (m < 3) check("settled", settled_o, k > m);
                else check("auto stage", 24'(filt_stage_o), 24'(k < 3 ? k : 2));
            end
        end
        $display("done: filters");
    endtask
    initial begin
        repeat (6) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        check("ready at reset", result_ready_n_o, 1'b1);
        check("idle select", dout_oe_o, 1'b0);
        test_ready();
        test_rates();
        test_sampling();
        test_three_wire();
        test_filters();
        report_and_stop();
    end
    // Cuts a hang short well after the expected run of about 75000 cycles.
    initial begin
        repeat (95000) @(posedge ref_clk_i);
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire
